/* File: include/serial_pkg.sv */
package serial_pkg;

  // ----
  // Clocking and rates
  // ----
  localparam int          CLK_HZ   = 25_000_000;
  localparam int          MAX_BAUD = 2_000_000;
  localparam int          RST_BAUD = 115_200;
  localparam logic [15:0] MIN_DIV  = 16'(CLK_HZ / MAX_BAUD);
  localparam logic [15:0] RST_DIV  = 16'(CLK_HZ / RST_BAUD);
  localparam int          NCH      = 2;
  localparam int          NPIN     = 4;

  // ----
  // Register offsets within a channel
  // ----
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_DIV  = 5'h04;
  localparam logic [4:0] OFS_TXD  = 5'h08;
  localparam logic [4:0] OFS_RXD  = 5'h0c;
  localparam logic [4:0] OFS_STAT = 5'h10;
  localparam logic [4:0] OFS_MASK = 5'h14;
  localparam logic [4:0] OFS_MAP  = 5'h18;
  localparam int         CH_BIT   = 5;

  // ----
  // Control fields
  // ----
  localparam int         CTL_STOP2 = 4;
  localparam int         CTL_PEN   = 5;
  localparam int         CTL_PODD  = 6;
  localparam int         CTL_TXEN  = 7;
  localparam int         CTL_RXEN  = 8;
  localparam logic [8:0] RST_CTRL  = 9'h188;
  localparam logic [3:0] RST_MAP0  = 4'h4;
  localparam logic [3:0] RST_MAP1  = 4'he;

  // ----
  // Status bits
  // ----
  localparam int ST_TXDONE  = 0;
  localparam int ST_TXEMPTY = 1;
  localparam int ST_RXDONE  = 2;
  localparam int ST_FRAME   = 3;
  localparam int ST_PAR     = 4;
  localparam int ST_OVER    = 5;
  localparam int ST_FALSE   = 6;
  localparam int ST_W       = 7;

  // Data bit count held to 5..9
  function automatic logic [3:0] eff_bits(logic [3:0] n);
    if (n < 4'h5) begin
      return 4'h5;
    end
    return (n > 4'h9) ? 4'h9 : n;
  endfunction : eff_bits

  // Parity over the low n data bits
  function automatic logic par_bit(logic [8:0] d, logic [3:0] n,
                                   logic odd);
    logic p;
    p = odd;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(n)) begin
        p = p ^ d[i];
      end
    end
    return p;
  endfunction : par_bit

endpackage : serial_pkg

/* File: verilog/serial_tx.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_tx import serial_pkg::*; (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Setup
  input  wire logic [15:0] div,
  input  wire logic [3:0]  nbits,
  input  wire logic        two_stop,
  input  wire logic        par_en,
  input  wire logic        par_odd,
  // Load
  input  wire logic        start,
  input  wire logic [8:0]  data,
  // Line and state
  output logic             txd,
  output logic             busy,
  output logic             done
);
  typedef enum logic [4:0] {
    T_IDLE  = 5'b00001,
    T_START = 5'b00010,
    T_DATA  = 5'b00100,
    T_PAR   = 5'b01000,
    T_STOP  = 5'b10000
  } tx_state_t;

  typedef struct packed {
    tx_state_t   st;
    logic [15:0] cnt;
    logic [3:0]  idx;
    logic [8:0]  sh;
    logic        p;
    logic        stop2;
    logic        done;
  } tx_t;

  tx_t  r;
  tx_t  n;
  logic tick;

  assign tick = (r.cnt == 16'h0000);

  always_comb begin
    n = r;
    n.done = 1'b0;
    n.cnt = tick ? div - 16'h0001 : r.cnt - 16'h0001;
    case (r.st)
      T_IDLE: begin
        n.cnt = div - 16'h0001;
        if (start) begin
          n.st = T_START;
          n.sh = data;
          n.idx = 4'h0;
          n.p = par_bit(data, eff_bits(nbits), par_odd);
          n.stop2 = two_stop;
        end
      end
      T_START: if (tick) n.st = T_DATA;
      T_DATA: if (tick) begin
        n.sh = r.sh >> 1;
        n.idx = r.idx + 4'h1;
        if (r.idx == eff_bits(nbits) - 4'h1) begin
          n.st = par_en ? T_PAR : T_STOP;
        end
      end
      T_PAR: if (tick) n.st = T_STOP;
      T_STOP: if (tick) begin
        if (r.stop2) begin
          n.stop2 = 1'b0;
        end else begin
          n.st = T_IDLE;
          n.done = 1'b1;
        end
      end
      default: n.st = T_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '0;
      r.st <= T_IDLE;
    end else begin
      r <= n;
    end
  end

  always_comb begin
    case (r.st)
      T_START: txd = 1'b0;
      T_DATA:  txd = r.sh[0];
      T_PAR:   txd = r.p;
      default: txd = 1'b1;
    endcase
  end

  assign busy = (r.st != T_IDLE);
  assign done = r.done;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_start_low;
    r.st == T_START |-> !txd;
  endproperty
  a_start_low: assert property (p_start_low)
    else $error("start bit not low");

  property p_two_stop;
    r.st == T_STOP && tick && r.stop2 |=> r.st == T_STOP && txd ##1 txd;
  endproperty
  a_two_stop: assert property (p_two_stop)
    else $error("second stop bit missing");

  property p_par_next;
    r.st == T_DATA && tick && par_en && r.idx == eff_bits(nbits) - 4'h1
      |=> r.st == T_PAR;
  endproperty
  a_par_next: assert property (p_par_next)
    else $error("parity bit not sent");
endmodule : serial_tx
`default_nettype wire

/* File: verilog/serial_rx.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_rx import serial_pkg::*; (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Setup
  input  wire logic [15:0] div,
  input  wire logic [3:0]  nbits,
  input  wire logic        par_en,
  input  wire logic        par_odd,
  input  wire logic        en,
  // Synchronised line
  input  wire logic        rxd,
  // Results
  output logic [8:0]       data,
  output logic             done,
  output logic             ferr,
  output logic             perr,
  output logic             fstart
);
  typedef enum logic [4:0] {
    R_IDLE  = 5'b00001,
    R_START = 5'b00010,
    R_DATA  = 5'b00100,
    R_PAR   = 5'b01000,
    R_STOP  = 5'b10000
  } rx_state_t;

  typedef struct packed {
    rx_state_t   st;
    logic [15:0] cnt;
    logic [3:0]  idx;
    logic [8:0]  sh;
    logic [2:0]  f;
    logic        lvl;
    logic        prev;
    logic        pb;
    logic        done;
    logic        ferr;
    logic        perr;
    logic        fs;
  } rx_t;

  rx_t  r;
  rx_t  n;
  logic tick;

  assign tick = (r.cnt == 16'h0000);

  always_comb begin
    n = r;
    n.done = 1'b0;
    n.ferr = 1'b0;
    n.perr = 1'b0;
    n.fs = 1'b0;
    n.f = {r.f[1:0], rxd};
    if (r.f == 3'b111) n.lvl = 1'b1;
    else if (r.f == 3'b000) n.lvl = 1'b0;
    n.prev = r.lvl;
    n.cnt = tick ? div - 16'h0001 : r.cnt - 16'h0001;
    case (r.st)
      R_IDLE: if (en && r.prev && !r.lvl) begin
        n.st = R_START;
        n.cnt = div >> 1;
        n.sh = 9'h000;
        n.idx = 4'h0;
      end
      R_START: if (tick) begin
        if (r.lvl) begin
          n.st = R_IDLE;
          n.fs = 1'b1;
        end else begin
          n.st = R_DATA;
        end
      end
      R_DATA: if (tick) begin
        n.sh[r.idx] = r.lvl;
        n.idx = r.idx + 4'h1;
        if (r.idx == eff_bits(nbits) - 4'h1) begin
          n.st = par_en ? R_PAR : R_STOP;
        end
      end
      R_PAR: if (tick) begin
        n.pb = r.lvl;
        n.st = R_STOP;
      end
      R_STOP: if (tick) begin
        n.st = R_IDLE;
        n.done = 1'b1;
        n.ferr = !r.lvl;
        n.perr = par_en &&
                 (r.pb != par_bit(r.sh, eff_bits(nbits), par_odd));
      end
      default: n.st = R_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '0;
      r.st <= R_IDLE;
      r.f <= 3'h7;
      r.lvl <= 1'b1;
      r.prev <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign data = r.sh;
  assign done = r.done;
  assign ferr = r.ferr;
  assign perr = r.perr;
  assign fstart = r.fs;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_filter;
    $changed(r.lvl) |-> $past(r.f) == 3'b111 || $past(r.f) == 3'b000;
  endproperty
  a_filter: assert property (p_filter)
    else $error("filtered level moved on a glitch");

  property p_false;
    r.st == R_START && tick && r.lvl |=> r.st == R_IDLE && fstart;
  endproperty
  a_false: assert property (p_false)
    else $error("false start not dropped");

  property p_frame;
    r.st == R_STOP && tick && !r.lvl |=> done && ferr;
  endproperty
  a_frame: assert property (p_frame)
    else $error("framing error missed");
endmodule : serial_rx
`default_nettype wire

/* File: verilog/dual_async_serial_port.sv */
`timescale 1ns/1ps
`default_nettype none
module dual_async_serial_port import serial_pkg::*; (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Device pins
  input  wire logic [3:0]  pin_in,
  output logic      [3:0]  pin_out,
  output logic      [3:0]  pin_oe,
  // Interrupt
  output logic             irq
);

  // ----
  // State
  // ----
  typedef struct packed {
    logic [NPIN-1:0]            sy1;
    logic [NPIN-1:0]            sy2;
    logic [NCH-1:0][8:0]        ctrl;
    logic [NCH-1:0][15:0]       div;
    logic [NCH-1:0][8:0]        hold;
    logic [NCH-1:0]             hfull;
    logic [NCH-1:0][8:0]        rbuf;
    logic [NCH-1:0]             rfull;
    logic [NCH-1:0][ST_W-1:0]   st;
    logic [NCH-1:0][ST_W-1:0]   mask;
    logic [NCH-1:0][3:0]        map;
    logic [NPIN-1:0]            pout;
    logic [NPIN-1:0]            poe;
    logic                       ack;
    logic [31:0]                dat;
    logic                       irq;
  } top_t;

  top_t                     r;
  top_t                     n;
  logic [NCH-1:0]           tx_go;
  logic [NCH-1:0]           tx_line;
  logic [NCH-1:0]           tx_busy;
  logic [NCH-1:0]           tx_done;
  logic [NCH-1:0]           rx_line;
  logic [NCH-1:0][8:0]      rx_data;
  logic [NCH-1:0]           rx_done;
  logic [NCH-1:0]           rx_ferr;
  logic [NCH-1:0]           rx_perr;
  logic [NCH-1:0]           rx_fs;
  logic [NCH-1:0]           rd_rx;
  logic [NCH-1:0][ST_W-1:0] clr;
  logic [NCH-1:0][ST_W-1:0] ev;
  logic                     req;
  logic                     ch;
  logic [4:0]               ofs;
  logic [31:0]              rd;
  logic [31:0]              w;
  logic [31:0]              wz;

  // Byte lane merge for writes
  function automatic logic [31:0] wmask(logic [31:0] old,
                                        logic [31:0] wd,
                                        logic [3:0]  sel);
    logic [31:0] v;
    v = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        v[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return v;
  endfunction : wmask

  // ----
  // Channels
  // ----
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    assign tx_go[c] = r.hfull[c] && !tx_busy[c] &&
                      r.ctrl[c][CTL_TXEN];
    assign rx_line[c] = r.sy2[r.map[c][3:2]];

    serial_tx u_tx (
      .clk      (clk),
      .rst_n    (rst_n),
      .div      (r.div[c]),
      .nbits    (r.ctrl[c][3:0]),
      .two_stop (r.ctrl[c][CTL_STOP2]),
      .par_en   (r.ctrl[c][CTL_PEN]),
      .par_odd  (r.ctrl[c][CTL_PODD]),
      .start    (tx_go[c]),
      .data     (r.hold[c]),
      .txd      (tx_line[c]),
      .busy     (tx_busy[c]),
      .done     (tx_done[c])
    );

    serial_rx u_rx (
      .clk     (clk),
      .rst_n   (rst_n),
      .div     (r.div[c]),
      .nbits   (r.ctrl[c][3:0]),
      .par_en  (r.ctrl[c][CTL_PEN]),
      .par_odd (r.ctrl[c][CTL_PODD]),
      .en      (r.ctrl[c][CTL_RXEN]),
      .rxd     (rx_line[c]),
      .data    (rx_data[c]),
      .done    (rx_done[c]),
      .ferr    (rx_ferr[c]),
      .perr    (rx_perr[c]),
      .fstart  (rx_fs[c])
    );
  end

  // ----
  // Register bus and events
  // ----
  always_comb begin
    n = r;
    n.sy1 = pin_in;
    n.sy2 = r.sy1;
    req = wb_cyc_i && wb_stb_i && !r.ack;
    n.ack = req;
    n.dat = 32'h0000_0000;
    ch = wb_adr_i[CH_BIT];
    ofs = {wb_adr_i[4:2], 2'b00};
    clr = '0;
    rd_rx = '0;
    rd = 32'h0000_0000;

    // Read decode
    if (wb_adr_i[7:6] != 2'b00) begin
      rd = 32'h0000_0000;
    end else if (ofs == OFS_CTRL) begin
      rd = {23'h000000, r.ctrl[ch]};
    end else if (ofs == OFS_DIV) begin
      rd = {16'h0000, r.div[ch]};
    end else if (ofs == OFS_RXD) begin
      rd = {23'h000000, r.rbuf[ch]};
    end else if (ofs == OFS_STAT) begin
      rd = {21'h000000, r.rfull[ch], r.hfull[ch], tx_busy[ch],
            1'b0, r.st[ch]};
    end else if (ofs == OFS_MASK) begin
      rd = {25'h0000000, r.mask[ch]};
    end else if (ofs == OFS_MAP) begin
      rd = {28'h0000000, r.map[ch]};
    end
    if (req && !wb_we_i) begin
      n.dat = rd;
    end
    w = wmask(rd, wb_dat_i, wb_sel_i);
    wz = wmask(32'h0000_0000, wb_dat_i, wb_sel_i);

    // Write and read side effects
    if (!req || wb_adr_i[7:6] != 2'b00) begin
      rd_rx = '0;
    end else if (ofs == OFS_CTRL) begin
      if (wb_we_i) n.ctrl[ch] = w[8:0];
    end else if (ofs == OFS_DIV) begin
      if (wb_we_i) begin
        n.div[ch] = (w[15:0] < MIN_DIV) ? MIN_DIV : w[15:0];
      end
    end else if (ofs == OFS_TXD) begin
      if (wb_we_i && !r.hfull[ch]) begin
        n.hold[ch] = w[8:0];
        n.hfull[ch] = 1'b1;
      end
    end else if (ofs == OFS_RXD) begin
      if (!wb_we_i) begin
        rd_rx[ch] = 1'b1;
        n.rfull[ch] = 1'b0;
      end
    end else if (ofs == OFS_STAT) begin
      if (wb_we_i) clr[ch] = wz[ST_W-1:0];
    end else if (ofs == OFS_MASK) begin
      if (wb_we_i) n.mask[ch] = w[ST_W-1:0];
    end else if (ofs == OFS_MAP) begin
      if (wb_we_i) n.map[ch] = w[3:0];
    end

    // Events; a set beats a clear in the same cycle
    for (int c = 0; c < NCH; c++) begin
      ev[c] = '0;
      ev[c][ST_TXDONE] = tx_done[c];
      ev[c][ST_TXEMPTY] = tx_go[c];
      ev[c][ST_RXDONE] = rx_done[c];
      ev[c][ST_FRAME] = rx_ferr[c];
      ev[c][ST_PAR] = rx_perr[c];
      ev[c][ST_OVER] = rx_done[c] && r.rfull[c] && !rd_rx[c];
      ev[c][ST_FALSE] = rx_fs[c];
      if (tx_go[c]) begin
        n.hfull[c] = 1'b0;
      end
      if (rx_done[c]) begin
        n.rbuf[c] = rx_data[c];
        n.rfull[c] = 1'b1;
      end
      n.st[c] = (r.st[c] & ~clr[c]) | ev[c];
    end

    // Pin mapping; channel 0 wins a shared pin
    n.pout = '1;
    n.poe = '0;
    for (int c = NCH - 1; c >= 0; c--) begin
      if (r.ctrl[c][CTL_TXEN]) begin
        n.pout[r.map[c][1:0]] = tx_line[c];
        n.poe[r.map[c][1:0]] = 1'b1;
      end
    end

    n.irq = |(n.st & n.mask);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '0;
      r.sy1 <= '1;
      r.sy2 <= '1;
      r.ctrl <= {NCH{RST_CTRL}};
      r.div <= {NCH{RST_DIV}};
      r.map <= {RST_MAP1, RST_MAP0};
      r.pout <= '1;
    end else begin
      r <= n;
    end
  end

  // ----
  // Outputs
  // ----
  assign wb_dat_o = r.dat;
  assign wb_ack_o = r.ack;
  assign pin_out = r.pout;
  assign pin_oe = r.poe;
  assign irq = r.irq;

  // ----
  // Checks
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("bus answer not a single cycle");

  property p_div_min;
    r.div[0] >= MIN_DIV && r.div[1] >= MIN_DIV;
  endproperty
  a_div_min: assert property (p_div_min)
    else $error("bit period below the fastest rate");

  property p_over;
    rx_done[0] && r.rfull[0] && !rd_rx[0] |=> r.st[0][ST_OVER];
  endproperty
  a_over: assert property (p_over)
    else $error("overflow not flagged");

  property p_empty;
    tx_go[0] |=> r.st[0][ST_TXEMPTY] && !r.hfull[0] && tx_busy[0];
  endproperty
  a_empty: assert property (p_empty)
    else $error("holding empty not flagged");

  property p_sent;
    tx_done[1] |=> r.st[1][ST_TXDONE];
  endproperty
  a_sent: assert property (p_sent)
    else $error("sent event lost");

  property p_irq;
    $rose(r.st[0][ST_RXDONE]) && r.mask[0][ST_RXDONE] |-> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("unmasked event gave no interrupt");

  property p_pin;
    r.ctrl[0][CTL_TXEN]
      |=> pin_oe[$past(r.map[0][1:0])] &&
          pin_out[$past(r.map[0][1:0])] == $past(tx_line[0]);
  endproperty
  a_pin: assert property (p_pin)
    else $error("transmit line not on its pin");

  property p_rx_buf;
    rx_done[1] |=> r.rfull[1] && r.rbuf[1] == $past(rx_data[1]);
  endproperty
  a_rx_buf: assert property (p_rx_buf)
    else $error("received character not held");

  property p_rdat;
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000;
  endproperty
  a_rdat: assert property (p_rdat)
    else $error("read data outside the answer cycle");

  property p_stat_clr;
    req && wb_we_i && wb_adr_i == {3'b000, OFS_STAT} && wb_sel_i[0] &&
      wb_dat_i[ST_RXDONE] && !rx_done[0] |=> !r.st[0][ST_RXDONE];
  endproperty
  a_stat_clr: assert property (p_stat_clr)
    else $error("status bit not cleared by a one");

  property p_indep;
    req && wb_we_i && wb_adr_i[CH_BIT]
      |=> $stable(r.ctrl[0]) && $stable(r.div[0]) && $stable(r.mask[0]);
  endproperty
  a_indep: assert property (p_indep)
    else $error("channel 1 write touched channel 0");

  property p_ferr_flag;
    rx_ferr[0] |=> r.st[0][ST_FRAME];
  endproperty
  a_ferr_flag: assert property (p_ferr_flag)
    else $error("framing event lost");

  property p_fs_flag;
    rx_fs[0] |=> r.st[0][ST_FALSE];
  endproperty
  a_fs_flag: assert property (p_fs_flag)
    else $error("false start event lost");

  c_dual: cover property (tx_busy[0] && tx_busy[1] && rx_done[0]);
  c_over: cover property (r.st[0][ST_OVER]);
  c_frame: cover property (rx_ferr[1]);
  c_irq: cover property ($rose(irq));

endmodule : dual_async_serial_port
`default_nettype wire

/* File: bench/serial_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
  // Clock
  input  wire logic clk,
  // Lines
  input  wire logic rx_line,
  output var logic  tx_line
);
  // ----------------------------------------
  // Far-side serial device
  // ----------------------------------------
  initial tx_line = 1'b1;

  task automatic put(input logic b, input int div);
    tx_line <= b;
    repeat (div) @(posedge clk);
  endtask : put

  task automatic send(input logic [8:0] d, input int n, input int div,
                      input logic pen, input logic podd,
                      input logic bad_par, input logic bad_stop);
    logic p;
    p = podd ^ bad_par;
    @(posedge clk);
    put(1'b0, div);
    for (int i = 0; i < n; i++) begin
      put(d[i], div);
      p = p ^ d[i];
    end
    if (pen) begin
      put(p, div);
    end
    put(~bad_stop, div);
    put(1'b1, div);
  endtask : send

  task automatic pulse(input int len, input int div);
    @(posedge clk);
    put(1'b0, len);
    put(1'b1, 2 * div);
  endtask : pulse

  task automatic grab(input int n, input int div, input logic pen,
                      input int nstop, output logic [8:0] d,
                      output logic p, output logic ok);
    int t;
    d = 'x;
    p = 1'bx;
    ok = 1'b0;
    t = 0;
    while (rx_line !== 1'b0 && t < 20000) begin
      @(posedge clk);
      t++;
    end
    repeat (div / 2) @(posedge clk);
    if (rx_line !== 1'b0) begin
      return;
    end
    d = '0;
    for (int i = 0; i < n; i++) begin
      repeat (div) @(posedge clk);
      d[i] = rx_line;
    end
    if (pen) begin
      repeat (div) @(posedge clk);
      p = rx_line;
    end
    ok = 1'b1;
    for (int i = 0; i < nstop; i++) begin
      repeat (div) @(posedge clk);
      ok = ok & (rx_line === 1'b1);
    end
  endtask : grab
endmodule : serial_peer
`default_nettype wire

/* File: bench/dual_async_serial_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module dual_async_serial_port_tb import serial_pkg::*;;
  logic        clk      = 1'b0;
  logic        rst_n    = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i  = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [3:0]  pin_out;
  logic [3:0]  pin_oe;
  logic        irq;
  logic        p0_tx;
  logic        p1_tx;
  int          err_total   = 0;
  int          comparisons = 0;
  wire  [3:0]  pin_in = {p1_tx, 1'b1, p0_tx, 1'b1};

  always #20 clk = ~clk;

  dual_async_serial_port i_dut (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
  serial_peer u_peer0 (.clk(clk), .rx_line(pin_out[0]), .tx_line(p0_tx));
  serial_peer u_peer1 (.clk(clk), .rx_line(pin_out[2]), .tx_line(p1_tx));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic bus(input logic we, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int t;
    t = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= wd;
    do begin
      @(posedge clk);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 100);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (t >= 100) begin
      chk("bus ack", 32'h1, 32'h0);
    end
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task automatic rdc(input string w, input logic [7:0] a,
                     input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(w, exp & m, x & m);
  endtask : rdc

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic s_reset;
    rdc("ctrl0", 8'h00, 32'h188, '1);
    rdc("div0", 8'h04, 32'hd9, '1);
    rdc("mask0", 8'h14, 32'h0, '1);
    rdc("map0", 8'h18, 32'h4, '1);
    rdc("map1", 8'h38, 32'he, '1);
    rdc("unmapped", 8'h1c, 32'h0, '1);
    rdc("outside", 8'h40, 32'h0, '1);
    chk("pin_oe", 32'h5, {28'h0, pin_oe});
    chk("pin_out", 32'hf, {28'h0, pin_out});
    wr(8'h04, 32'h10);
    rdc("div set", 8'h04, 32'h10, '1);
    wr(8'h24, 32'h5);
    rdc("div floor", 8'h24, 32'hc, '1);
    $display("test reset done");
  endtask : s_reset

  task automatic s_frames;
    logic [8:0]  d, e, got;
    logic        p, ok, pen, podd, two;
    logic [31:0] m;
    int          n;
    wr(8'h10, 32'h7f);
    for (int i = 0; i < 5; i++) begin
      n = 5 + i;
      two = i[0];
      pen = (i != 2);
      podd = i[1];
      m = (32'h1 << n) - 32'h1;
      d = 9'h1a5 ^ 9'(i * 37);
      e = ~d;
      wr(8'h00, {23'h0, 2'b11, podd, pen, two, 4'(n)});
      fork
        u_peer0.grab(n, 16, pen, two ? 2 : 1, got, p, ok);
        u_peer0.send(e, n, 16, pen, podd, 1'b0, 1'b0);
        wr(8'h08, {23'h0, d});
      join
      repeat (16) @(posedge clk);
      chk("tx data", d & m, {23'h0, got});
      if (pen) begin
        chk("tx parity", {31'h0, ^(d & m[8:0]) ^ podd}, {31'h0, p});
      end
      chk("tx stop", 32'h1, {31'h0, ok});
      rdc("stat", 8'h10, 32'h7, 32'h7f);
      rdc("rx data", 8'h0c, e & m, '1);
      wr(8'h10, 32'h7f);
    end
    $display("test frames done");
  endtask : s_frames

  task automatic s_errors;
    logic [6:0] st [5] = '{7'h14, 7'h0c, 7'h40, 7'h00, 7'h24};
    logic [8:0] rv [5] = '{9'h03c, 9'h03c, 9'h03c, 9'h03c, 9'h022};
    wr(8'h00, 32'h1a8);
    for (int k = 0; k < 5; k++) begin
      case (k)
        0: u_peer0.send(9'h3c, 8, 16, 1'b1, 1'b0, 1'b1, 1'b0);
        1: u_peer0.send(9'h3c, 8, 16, 1'b1, 1'b0, 1'b0, 1'b1);
        2: u_peer0.pulse(5, 16);
        3: u_peer0.pulse(2, 16);
        default: begin
          u_peer0.send(9'h11, 8, 16, 1'b1, 1'b0, 1'b0, 1'b0);
          u_peer0.send(9'h22, 8, 16, 1'b1, 1'b0, 1'b0, 1'b0);
          rdc("rx last", 8'h0c, 32'h22, '1);
        end
      endcase
      rdc("err stat", 8'h10, {25'h0, st[k]}, 32'h7f);
      rdc("rx read", 8'h0c, {23'h0, rv[k]}, '1);
      wr(8'h10, 32'h7f);
    end
    $display("test errors done");
  endtask : s_errors

  task automatic s_irq;
    wr(8'h14, 32'h4);
    u_peer0.send(9'h5a, 8, 16, 1'b1, 1'b0, 1'b0, 1'b0);
    repeat (2) @(posedge clk);
    chk("irq rx", 32'h1, {31'h0, irq});
    wr(8'h14, 32'h3);
    repeat (2) @(posedge clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(8'h14, 32'h4);
    rdc("mask", 8'h14, 32'h4, '1);
    wr(8'h10, 32'h4);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rdc("rx val", 8'h0c, 32'h5a, '1);
    $display("test irq done");
  endtask : s_irq

  task automatic s_ch1;
    logic [8:0] got;
    logic       p, ok;
    wr(8'h20, 32'h187);
    wr(8'h30, 32'h7f);
    wr(8'h34, 32'h1);
    fork
      u_peer1.grab(7, 12, 1'b0, 1, got, p, ok);
      u_peer1.send(9'h13, 7, 12, 1'b0, 1'b0, 1'b0, 1'b0);
      wr(8'h28, 32'h6c);
    join
    repeat (12) @(posedge clk);
    chk("ch1 tx", 32'h6c, {23'h0, got});
    chk("ch1 irq", 32'h1, {31'h0, irq});
    rdc("ch1 rx", 8'h2c, 32'h13, '1);
    wr(8'h30, 32'h7f);
    repeat (2) @(posedge clk);
    chk("ch1 irq off", 32'h0, {31'h0, irq});
    wr(8'h18, 32'h7);
    repeat (2) @(posedge clk);
    chk("remap oe", 32'hc, {28'h0, pin_oe});
    wr(8'h18, 32'h4);
    wr(8'h00, 32'h108);
    repeat (2) @(posedge clk);
    chk("tx off oe", 32'h4, {28'h0, pin_oe});
    $display("test ch1 done");
  endtask : s_ch1

  task automatic stop_test;
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    s_reset;
    s_frames;
    s_errors;
    s_irq;
    s_ch1;
    stop_test;
  end

  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    stop_test;
  end
endmodule : dual_async_serial_port_tb
`default_nettype wire
